// ### rtl/ext_bus_ctrl.sv
// External bus strobes, byte enables, ready wait states and pin sharing
`timescale 1ns/1ps
// Behaviour
// - Full write strobe mode: strobe low on every external write.
// - Low-byte strobe mode: strobe low only when the even byte is written.
// - Strobe pin only strobes on external writes, else held high; plain I/O bit when not selected.
// - High bank selected by byte-high enable low, low bank by addr bit0 low.
// - Sixteen-bit lanes: low 0/1, high 1/0, both 0/0 as addr_bit0/bhe.
// - High-byte write mode: pin low only when writing an odd location.
// - Byte-high pin meaningful only in 16-bit cycles, else general I/O.
// - Strobe flavours taken from chip configuration inputs.
// - Ready high means bus cycles complete with no wait states.
// - Ready low before clock fall waits until rising edge with ready high.
// - Ready ignored for any cycle not on external memory.
// - Wait states per cycle capped at configured maximum.
// - Interrupt-out low while a pending interrupt needs the external bus.
// - Extended port pins each choose extended address or I/O.
// - Address/data pins are open-drain ports unless driving the bus strongly.
// - Dynamic width: width input low gives 8-bit, high gives 16-bit cycle.
// - Address-valid returns high at the end of each bus cycle.
module ext_bus_ctrl #(
    parameter int MAX_WAIT_W = ext_bus_pkg::WAIT_W
) (
    input  wire logic                               sys_clk,
    input  wire logic                               reset_n,
    input  wire logic                               reqValid,
    input  wire logic                               reqWrite,
    input  wire logic [ext_bus_pkg::ADDR_W-1:0]     reqAddr,
    input  wire logic [ext_bus_pkg::DATA_W-1:0]     reqWdata,
    input  wire ext_bus_pkg::lanes_t                reqLanes,
    output logic                                    reqReady,
    output logic                                    rspValid,
    output logic [ext_bus_pkg::DATA_W-1:0]          rspData,
    input  wire logic                               cfgWrLowByte,
    input  wire logic                               cfgWrhMode,
    input  wire logic                               cfgStrobeSel,
    input  wire logic                               cfgByteHighSel,
    input  wire logic                               cfgReadySel,
    input  wire logic                               cfgAdvSel,
    input  wire logic                               cfgBusDynamic,
    input  wire logic                               cfgBus16,
    input  wire logic [MAX_WAIT_W-1:0]              cfgMaxWait,
    input  wire logic                               lsioStrobeBit,
    input  wire logic                               lsioHighBit,
    input  wire logic                               lsioAdvBit,
    input  wire logic [ext_bus_pkg::EXT_W-1:0]      eportSel,
    input  wire logic [ext_bus_pkg::EXT_W-1:0]      eportIo,
    input  wire logic [ext_bus_pkg::EXT_W-1:0]      eportIoOe,
    input  wire logic [ext_bus_pkg::DATA_W-1:0]     adPortIo,
    input  wire logic                               intPending,
    input  wire logic                               intNeedsBus,
    input  wire logic                               readyPin,
    input  wire logic                               busWidthPin,
    input  wire logic [ext_bus_pkg::DATA_W-1:0]     adIn,
    output logic                                    half_rate_clock_out,
    output logic                                    address_valid_n,
    output logic                                    write_strobe_n,
    output logic                                    byte_high_en_n,
    output logic                                    addr_bit0,
    output logic [ext_bus_pkg::DATA_W-1:0]          adOut,
    output logic [ext_bus_pkg::DATA_W-1:0]          adOe,
    output logic [ext_bus_pkg::EXT_W-1:0]           eportOut,
    output logic [ext_bus_pkg::EXT_W-1:0]           eportOe,
    output logic                                    bus_interrupt_out_n,
    output logic                                    busActive
);
    import ext_bus_pkg::*;

    bus_state_e               state_r;
    logic                     half_rate_clock_out_r;
    logic                     readyMeta_r, readySync_r;
    logic                     widthMeta_r, widthSync_r;
    logic [DATA_W-1:0]        adMeta_r, adSync_r;
    logic                     jobValid_r, jobWrite_r, hiPending_r;
    logic [ADDR_W-1:0]        jobAddr_r;
    logic [DATA_W-1:0]        jobData_r;
    lanes_t                   jobLanes_r, cycLanes_r;
    logic                     cyc16_r, readyLow_r;
    logic [MAX_WAIT_W-1:0]    waitCnt_r;
    logic                     reqReady_r, rspValid_r;
    logic [DATA_W-1:0]        rspData_r;
    logic                     advN_r, strobeN_r, bheN_r, a0_r, intN_r, busy_r;
    logic [DATA_W-1:0]        adOut_r, adOe_r;
    logic [EXT_W-1:0]         epOut_r, epOe_r;
    logic                     rise, fall, take, width16, cycHi, inStrobe;
    logic                     waitDone, lastCycle;
    logic [DATA_W-1:0]        wrLanes;

    pin_share_if #(.N(EXT_W))  epIf ();
    pin_share_if #(.N(DATA_W)) adIf ();

    pin_share_mux #(.N(EXT_W), .OPEN_DRAIN(1'b0)) u_extended_addr_port (.pins(epIf));
    pin_share_mux #(.N(DATA_W), .OPEN_DRAIN(1'b1)) u_adport (.pins(adIf));

    // Phase of the output clock: transitions are taken where it rises
    assign rise = (half_rate_clock_out_r == CLK_RST);
    assign fall = ~rise;
    assign take = reqValid & reqReady_r;
    assign width16 = cfgBusDynamic ? widthSync_r : cfgBus16;
    assign cycHi = cycLanes_r[LANE_HI];
    assign inStrobe = (state_r == ST_STROBE) || (state_r == ST_WAIT);
    assign waitDone = readySync_r || ((waitCnt_r + WAIT_ONE) >= cfgMaxWait);
    assign lastCycle = ~(jobLanes_r[LANE_LO] & jobLanes_r[LANE_HI] & ~cyc16_r)
                       | hiPending_r;
    assign wrLanes = cyc16_r ? jobData_r
                   : (cycHi ? {{BYTE_W{1'b0}}, jobData_r[DATA_W-1:BYTE_W]} : jobData_r);

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
            half_rate_clock_out_r <= CLK_RST;
        else
            half_rate_clock_out_r <= ~half_rate_clock_out_r;
    end

    // Pin inputs cross in through two flops each
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            readyMeta_r <= PIN_HIGH;
            readySync_r <= PIN_HIGH;
            widthMeta_r <= PIN_LOW;
            widthSync_r <= PIN_LOW;
            adMeta_r    <= '0;
            adSync_r    <= '0;
        end
        else
        begin
            readyMeta_r <= readyPin;
            readySync_r <= readyMeta_r;
            widthMeta_r <= busWidthPin;
            widthSync_r <= widthMeta_r;
            adMeta_r    <= adIn;
            adSync_r    <= adMeta_r;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            jobValid_r <= 1'b0;
            jobWrite_r <= 1'b0;
            jobAddr_r  <= '0;
            jobData_r  <= '0;
            jobLanes_r <= LANES_NONE;
            reqReady_r <= 1'b1;
        end
        else if (take)
        begin
            jobValid_r <= 1'b1;
            jobWrite_r <= reqWrite;
            jobAddr_r  <= reqAddr;
            jobData_r  <= reqWdata;
            jobLanes_r <= reqLanes;
            reqReady_r <= 1'b0;
        end
        else if (state_r == ST_END && rise && lastCycle)
        begin
            jobValid_r <= 1'b0;
            reqReady_r <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            state_r     <= ST_IDLE;
            cycLanes_r  <= LANES_NONE;
            cyc16_r     <= 1'b0;
            hiPending_r <= 1'b0;
            readyLow_r  <= 1'b0;
            waitCnt_r   <= '0;
        end
        else
        begin
            unique case (state_r)
                ST_IDLE:
                    if (jobValid_r && rise)
                    begin
                        state_r   <= ST_ADDR;
                        cyc16_r   <= width16;
                        waitCnt_r <= '0;
                        // Eight-bit bus splits a word into low then high byte
                        if (width16)
                            cycLanes_r <= jobLanes_r;
                        else if (jobLanes_r[LANE_LO] && !hiPending_r)
                            cycLanes_r <= LANES_LO;
                        else
                            cycLanes_r <= LANES_HI;
                    end
                ST_ADDR:
                    if (rise)
                        state_r <= ST_STROBE;
                ST_STROBE:
                begin
                    if (fall)
                        readyLow_r <= ~readySync_r;
                    if (rise)
                    begin
                        if (readyLow_r && cfgReadySel && cfgMaxWait != WAIT_NONE)
                            state_r <= ST_WAIT;
                        else
                            state_r <= ST_END;
                    end
                end
                ST_WAIT:
                    if (rise)
                    begin
                        waitCnt_r <= waitCnt_r + WAIT_ONE;
                        if (waitDone)
                            state_r <= ST_END;
                    end
                ST_END:
                    if (rise)
                    begin
                        state_r     <= ST_IDLE;
                        readyLow_r  <= 1'b0;
                        hiPending_r <= ~lastCycle;
                    end
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end

    // Read data taken as the cycle closes: the pin synchroniser lags two clocks
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            rspValid_r <= 1'b0;
            rspData_r  <= '0;
        end
        else
        begin
            rspValid_r <= (state_r == ST_END) && rise && lastCycle && !jobWrite_r;
            if (state_r == ST_END && rise && !jobWrite_r)
            begin
                if (cyc16_r)
                    rspData_r <= adSync_r;
                else if (cycHi)
                    rspData_r[DATA_W-1:BYTE_W] <= adSync_r[BYTE_W-1:0];
                else
                    rspData_r[BYTE_W-1:0] <= adSync_r[BYTE_W-1:0];
            end
        end
    end

    // Shared-pin bundles
    assign epIf.sel     = eportSel;
    assign epIf.busBits = jobAddr_r[ADDR_W-1:LOW_ADDR_W];
    assign epIf.busOe   = {EXT_W{state_r != ST_IDLE}};
    assign epIf.ioBits  = eportIo;
    assign epIf.ioOe    = eportIoOe;

    assign adIf.sel     = {DATA_W{state_r != ST_IDLE}};
    assign adIf.busBits = (state_r == ST_ADDR)
                        ? {jobAddr_r[LOW_ADDR_W-1:1], ~cycLanes_r[LANE_LO] & ~cyc16_r | cycHi
                           & ~cycLanes_r[LANE_LO]}
                        : wrLanes;
    assign adIf.busOe   = {DATA_W{state_r == ST_ADDR || (jobWrite_r && state_r != ST_IDLE)}};
    assign adIf.ioBits  = adPortIo;
    assign adIf.ioOe    = '0;

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            advN_r    <= PIN_HIGH;
            strobeN_r <= PIN_HIGH;
            bheN_r    <= PIN_HIGH;
            a0_r      <= PIN_LOW;
            busy_r    <= 1'b0;
        end
        else
        begin
            busy_r <= (state_r != ST_IDLE);
            if (!cfgAdvSel)
                advN_r <= lsioAdvBit;
            else
                advN_r <= ~(state_r == ST_ADDR || inStrobe);
            if (!cfgStrobeSel)
                strobeN_r <= lsioStrobeBit;
            else if (inStrobe && jobWrite_r)
                strobeN_r <= cfgWrLowByte ? ~cycLanes_r[LANE_LO] : PIN_LOW;
            else
                strobeN_r <= PIN_HIGH;
            if (!cfgByteHighSel || !cyc16_r || state_r == ST_IDLE)
                bheN_r <= lsioHighBit;
            else if (cfgWrhMode)
                bheN_r <= ~(inStrobe && jobWrite_r && cycHi);
            else
                bheN_r <= ~cycHi;
            if (state_r != ST_IDLE)
                a0_r <= ~cycLanes_r[LANE_LO];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            adOut_r <= '0;
            adOe_r  <= '0;
            epOut_r <= '0;
            epOe_r  <= '0;
            intN_r  <= PIN_HIGH;
        end
        else
        begin
            adOut_r <= adIf.pinOut;
            adOe_r  <= adIf.pinOe;
            epOut_r <= epIf.pinOut;
            epOe_r  <= epIf.pinOe;
            intN_r  <= ~(intPending & intNeedsBus);
        end
    end

    assign reqReady            = reqReady_r;
    assign rspValid            = rspValid_r;
    assign rspData             = rspData_r;
    assign half_rate_clock_out = half_rate_clock_out_r;
    assign address_valid_n     = advN_r;
    assign write_strobe_n      = strobeN_r;
    assign byte_high_en_n      = bheN_r;
    assign addr_bit0           = a0_r;
    assign adOut               = adOut_r;
    assign adOe                = adOe_r;
    assign eportOut            = epOut_r;
    assign eportOe             = epOe_r;
    assign bus_interrupt_out_n = intN_r;
    assign busActive           = busy_r;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    sequence s_strobe_open;
        inStrobe && rise;
    endsequence
    sequence s_close;
        ##[1:8] (state_r == ST_END);
    endsequence

    AST_FULL_STROBE: assert property (
        (state_r == ST_STROBE && jobWrite_r && cfgStrobeSel && !cfgWrLowByte)
        |=> !write_strobe_n)
        else $error("full strobe not low in write");
    AST_LOW_STROBE: assert property (
        (inStrobe && cfgStrobeSel && cfgWrLowByte && !cycLanes_r[LANE_LO])
        |=> write_strobe_n)
        else $error("low strobe on odd byte");
    AST_STROBE_READ: assert property (
        (cfgStrobeSel && !jobWrite_r && $stable(cfgStrobeSel)) |=> write_strobe_n)
        else $error("strobe low on read");
    AST_A0_LANE: assert property (
        (state_r != ST_IDLE && cycLanes_r == LANES_HI) |=> addr_bit0)
        else $error("addr_bit0 wrong for high byte");
    AST_NO_WAIT: assert property (
        (state_r == ST_STROBE && readySync_r && $past(readySync_r) && rise) |=> state_r == ST_END)
        else $error("wait inserted with ready high");
    AST_READY_IGN: assert property (
        (state_r == ST_STROBE && rise && !cfgReadySel) |=> state_r == ST_END)
        else $error("wait outside external cycle");
    AST_WAIT_CAP: assert property (
        (state_r == ST_WAIT) |-> waitCnt_r < cfgMaxWait)
        else $error("wait count over cap");
    AST_CAP_END: assert property (
        s_strobe_open |-> s_close ##0 (waitCnt_r <= cfgMaxWait) or ##[9:40] (state_r == ST_END))
        else $error("cycle not closed");
    AST_INT_OUT: assert property (
        (intPending && intNeedsBus) |=> !bus_interrupt_out_n)
        else $error("interrupt out not low");
    AST_ADV_END: assert property (
        (cfgAdvSel && state_r == ST_IDLE && $past(state_r) == ST_END) |=> address_valid_n)
        else $error("address valid not released");
endmodule // ext_bus_ctrl

// ### rtl/ext_bus_pkg.sv
// Shared constants and types of the external bus strobe and ready controller
package ext_bus_pkg;
    localparam int DATA_W     = 16;
    localparam int BYTE_W     = 8;
    localparam int LOW_ADDR_W = 16;
    localparam int EXT_W      = 8;
    localparam int ADDR_W     = LOW_ADDR_W + EXT_W;
    localparam int WAIT_W     = 3;
    localparam int LANE_LO    = 0;
    localparam int LANE_HI    = 1;
    localparam int A0_BIT     = 0;

    typedef logic [1:0] lanes_t;
    localparam lanes_t LANES_NONE = 2'h0;
    localparam lanes_t LANES_LO   = 2'h1;
    localparam lanes_t LANES_HI   = 2'h2;

    localparam logic [WAIT_W-1:0] WAIT_NONE = 3'h0;
    localparam logic [WAIT_W-1:0] WAIT_ONE  = 3'h1;
    localparam logic [WAIT_W-1:0] WAIT_MAX_RST = 3'h3;

    localparam logic PIN_HIGH = 1'b1;
    localparam logic PIN_LOW  = 1'b0;
    localparam logic CLK_RST  = 1'b0;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_ADDR   = 3'h1,
        ST_STROBE = 3'h2,
        ST_WAIT   = 3'h3,
        ST_END    = 3'h4
    } bus_state_e;
endpackage

// ### rtl/pin_share_if.sv
// Bundle between the controller and its shared-pin multiplexer
`timescale 1ns/1ps
interface pin_share_if #(parameter int N = 8);
    logic [N-1:0] sel;
    logic [N-1:0] busBits;
    logic [N-1:0] busOe;
    logic [N-1:0] ioBits;
    logic [N-1:0] ioOe;
    logic [N-1:0] pinOut;
    logic [N-1:0] pinOe;
    modport mux  (input sel, busBits, busOe, ioBits, ioOe, output pinOut, pinOe);
    modport user (output sel, busBits, busOe, ioBits, ioOe, input pinOut, pinOe);
endinterface

// ### rtl/pin_share_mux.sv
// Per-pin choice between bus function and port function
`timescale 1ns/1ps
module pin_share_mux #(
    parameter int N          = 8,
    parameter bit OPEN_DRAIN = 1'b0
) (
    pin_share_if.mux pins
);
    import ext_bus_pkg::*;

    for (genvar i = 0; i < N; i++)
    begin : g_pin
        always_comb
        begin
            if (pins.sel[i])
            begin
                pins.pinOut[i] = pins.busBits[i];
                pins.pinOe[i]  = pins.busOe[i];
            end
            else if (OPEN_DRAIN)
            begin
                // Port mode only pulls low; a one floats
                pins.pinOut[i] = PIN_LOW;
                pins.pinOe[i]  = ~pins.ioBits[i];
            end
            else
            begin
                pins.pinOut[i] = pins.ioBits[i];
                pins.pinOe[i]  = pins.ioOe[i];
            end
        end
    end
endmodule // pin_share_mux

// ### sim/ext_mem_model.sv
// Behavioural external memory on the multiplexed address/data bus
`timescale 1ns/1ps
module ext_mem_model (
    input  wire logic        sys_clk,
    input  wire logic        address_valid_n,
    input  wire logic        write_strobe_n,
    input  wire logic        byte_high_en_n,
    input  wire logic        addr_bit0,
    input  wire logic [15:0] adOut,
    input  wire logic [15:0] adOe,
    input  wire logic        wrhMode,
    input  wire logic        bus8,
    input  wire logic [7:0]  waitClocks,
    output logic             readyPin,
    output logic [15:0]      adIn
);
    logic [15:0] mem [0:255];
    logic [7:0]  idx = 8'h00;
    logic [7:0]  waitCnt = 8'h00;
    logic        advPrev = 1'b1;
    logic        wrHit = 1'b0;
    logic        a0Lat = 1'b0;
    logic        bheLat = 1'b1;
    logic [15:0] dataLat = 16'h0000;

    always @(posedge sys_clk)
    begin
        advPrev <= address_valid_n;
        if (advPrev && !address_valid_n)
        begin
            idx <= adOut[8:1];
            a0Lat <= addr_bit0;
            bheLat <= byte_high_en_n;
            waitCnt <= 8'h00;
            wrHit <= 1'b0;
        end
        else if (!address_valid_n)
        begin
            if (waitCnt != 8'hFF)
                waitCnt <= waitCnt + 8'h01;
            if (!write_strobe_n || (wrhMode && !byte_high_en_n))
            begin
                wrHit <= 1'b1;
                dataLat <= adOe != 16'h0000 ? adOut : dataLat;
            end
        end
        else if (!advPrev && wrHit)
        begin
            // Narrow cycles carry either byte on the low lane
            if (bus8 && a0Lat)
                mem[idx][15:8] <= dataLat[7:0];
            else if (bus8)
                mem[idx][7:0] <= dataLat[7:0];
            else
            begin
                if (!a0Lat)
                    mem[idx][7:0] <= dataLat[7:0];
                if (!bheLat)
                    mem[idx][15:8] <= dataLat[15:8];
            end
        end
    end

    // Slow memory keeps ready low until it has counted its clocks
    assign readyPin = (waitClocks == 8'h00) || (!address_valid_n && waitCnt >= waitClocks);
    // Released bus floats to the pull-up level
    assign adIn = (!address_valid_n && adOe == 16'h0000)
                ? (bus8 && a0Lat ? {8'hFF, mem[idx][15:8]} : mem[idx]) : 16'hFFFF;
endmodule // ext_mem_model

// ### sim/tb.sv
// Self-checking bench for the external bus strobe and ready controller
`timescale 1ns/1ps
module tb;
    import ext_bus_pkg::*;
    logic sys_clk = 1'b0, reset_n = 1'b0, reqValid = 1'b0, reqWrite = 1'b0;
    logic [ADDR_W-1:0] reqAddr = '0;
    logic [DATA_W-1:0] reqWdata = '0;
    lanes_t reqLanes = LANES_NONE;
    logic reqReady, rspValid, halfClk, advN, strobeN, bheN, a0, intN, busActive, readyPin;
    logic [DATA_W-1:0] rspData, adOut, adOe, adIn, rd;
    logic wrLow = 1'b0, wrhMode = 1'b0, strobeSel = 1'b1, readySel = 1'b0, lsioStrobe = 1'b1;
    logic dynamic = 1'b0, bus16 = 1'b1, widthPin = 1'b1, intPending = 1'b0, intNeeds = 1'b0;
    logic [2:0] maxWait = 3'h2;
    logic [7:0] eportOut, eportOe, eportLat, waitClocks = 8'h00;
    logic strobeSeen, bheSeen, a0Lat, bheLat, advPrev = 1'b1;
    logic byteHighSel = 1'b1, lsioHigh = 1'b1, advSel = 1'b1, lsioAdv = 1'b1;
    logic [8:0] busLat;
    int errors = 0, tests_run = 0, cyc, n0, advCnt;

    always #2.5 sys_clk = ~sys_clk;

    ext_bus_ctrl uut (.sys_clk(sys_clk), .reset_n(reset_n), .reqValid(reqValid),
        .reqWrite(reqWrite), .reqAddr(reqAddr), .reqWdata(reqWdata), .reqLanes(reqLanes),
        .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData), .cfgWrLowByte(wrLow),
        .cfgWrhMode(wrhMode), .cfgStrobeSel(strobeSel), .cfgByteHighSel(byteHighSel),
        .cfgReadySel(readySel), .cfgAdvSel(advSel), .cfgBusDynamic(dynamic), .cfgBus16(bus16),
        .cfgMaxWait(maxWait), .lsioStrobeBit(lsioStrobe), .lsioHighBit(lsioHigh),
        .lsioAdvBit(lsioAdv), .eportSel(8'h0F), .eportIo(8'h30), .eportIoOe(8'hFF),
        .adPortIo(16'hFFFF), .intPending(intPending), .intNeedsBus(intNeeds),
        .readyPin(readyPin), .busWidthPin(widthPin), .adIn(adIn),
        .half_rate_clock_out(halfClk), .address_valid_n(advN), .write_strobe_n(strobeN),
        .byte_high_en_n(bheN), .addr_bit0(a0), .adOut(adOut), .adOe(adOe),
        .eportOut(eportOut), .eportOe(eportOe), .bus_interrupt_out_n(intN),
        .busActive(busActive));

    ext_mem_model mem_model (.sys_clk(sys_clk), .address_valid_n(advN),
        .write_strobe_n(strobeN), .byte_high_en_n(bheN), .addr_bit0(a0), .adOut(adOut),
        .adOe(adOe), .wrhMode(wrhMode), .bus8(dynamic ? !widthPin : !bus16),
        .waitClocks(waitClocks), .readyPin(readyPin), .adIn(adIn));

    always @(posedge sys_clk)
    begin
        advPrev <= advN;
        if (!strobeN)
            strobeSeen <= 1'b1;
        if (!bheN)
            bheSeen <= 1'b1;
        if (advPrev && !advN)
        begin
            advCnt <= advCnt + 1;
            a0Lat <= a0;
            bheLat <= bheN;
            eportLat <= eportOut;
            busLat <= {busActive, eportOe};
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic op(input logic wr, input logic [23:0] addr, input logic [15:0] data,
                      input lanes_t ln);
        int n;
        @(negedge sys_clk);
        // Start on a fixed output-clock phase so cycle counts repeat
        while (halfClk !== 1'b0)
            @(negedge sys_clk);
        strobeSeen = 1'b0;
        bheSeen = 1'b0;
        advCnt = 0;
        reqValid = 1'b1;
        reqWrite = wr;
        reqAddr = addr;
        reqWdata = data;
        reqLanes = ln;
        n = 0;
        while (reqReady !== 1'b1 && n < 500)
        begin
            @(negedge sys_clk);
            n++;
        end
        @(negedge sys_clk);
        reqValid = 1'b0;
        cyc = 1;
        // Ready drops on the same edge as the take; writes still count one clock more
        if (wr)
        begin
            @(negedge sys_clk);
            cyc++;
        end
        while (((wr && reqReady !== 1'b1) || (!wr && rspValid !== 1'b1)) && cyc < 500)
        begin
            @(negedge sys_clk);
            cyc++;
        end
        rd = rspData;
        check(cyc < 500, 1'b1);
    endtask

    task automatic settle;
        repeat (4) @(negedge sys_clk);
    endtask

    task automatic finish_test;
        if (errors == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        #200000;
        errors++;
        $display("CHECK FAILED at %0t: timeout", $time);
        finish_test();
    end

    initial
    begin
        repeat (6) @(posedge sys_clk);
        @(negedge sys_clk);
        reset_n = 1'b1;
        check(halfClk, 1'b0);
        check(strobeN, 1'b1);
        check(intN, 1'b1);
        @(negedge sys_clk);
        check(halfClk, 1'b1);
        op(1'b1, 24'hA50010, 16'hBEEF, 2'h3);
        n0 = cyc;
        check(strobeSeen, 1'b1);
        check({a0Lat, bheLat}, 2'b00);
        check(eportLat, 8'h35);
        check(busLat, 9'h1FF);
        check(advN, 1'b1);
        op(1'b0, 24'hA50010, 16'h0000, 2'h3);
        check(rd, 16'hBEEF);
        op(1'b1, 24'hA50020, 16'h0012, LANES_LO);
        check({a0Lat, bheLat}, 2'b01);
        op(1'b1, 24'hA50021, 16'h5600, LANES_HI);
        check({a0Lat, bheLat}, 2'b10);
        op(1'b0, 24'hA50020, 16'h0000, 2'h3);
        check(rd, 16'h5612);
        wrLow = 1'b1;
        op(1'b1, 24'hA50021, 16'h7700, LANES_HI);
        check(strobeSeen, 1'b0);
        op(1'b1, 24'hA50020, 16'h0034, LANES_LO);
        check(strobeSeen, 1'b1);
        wrLow = 1'b0;
        wrhMode = 1'b1;
        op(1'b1, 24'hA50040, 16'h0011, LANES_LO);
        check(bheSeen, 1'b0);
        op(1'b1, 24'hA50041, 16'h2200, LANES_HI);
        check(bheSeen, 1'b1);
        wrhMode = 1'b0;
        strobeSel = 1'b0;
        lsioStrobe = 1'b0;
        {byteHighSel, lsioHigh, advSel, lsioAdv} = 4'h0;
        settle();
        check(strobeN, 1'b0);
        check(bheN, 1'b0);
        check(advN, 1'b0);
        {lsioStrobe, byteHighSel, lsioHigh, advSel, lsioAdv} = 5'h1F;
        op(1'b1, 24'hA50050, 16'h0101, 2'h3);
        check(strobeSeen, 1'b0);
        strobeSel = 1'b1;
        intPending = 1'b1;
        settle();
        check(intN, 1'b1);
        intNeeds = 1'b1;
        settle();
        check(intN, 1'b0);
        intPending = 1'b0;
        settle();
        check(intN, 1'b1);
        dynamic = 1'b1;
        bus16 = 1'b0;
        widthPin = 1'b0;
        settle();
        op(1'b1, 24'hA50060, 16'hCAFE, 2'h3);
        check(advCnt, 2);
        check(bheSeen, 1'b0);
        widthPin = 1'b1;
        settle();
        op(1'b0, 24'hA50060, 16'h0000, 2'h3);
        check(advCnt, 1);
        check(rd, 16'hCAFE);
        dynamic = 1'b0;
        bus16 = 1'b1;
        readySel = 1'b1;
        op(1'b1, 24'hA50070, 16'h0F0F, 2'h3);
        check(cyc, n0);
        readySel = 1'b0;
        waitClocks = 8'hFF;
        op(1'b1, 24'hA50070, 16'h0F0F, 2'h3);
        check(cyc, n0);
        readySel = 1'b1;
        op(1'b1, 24'hA50070, 16'h0F0F, 2'h3);
        check(cyc > n0 && cyc <= n0 + 2 * 2 + 2, 1'b1);
        maxWait = 3'h7;
        waitClocks = 8'h08;
        op(1'b1, 24'hA50070, 16'h0F0F, 2'h3);
        check(cyc > n0 && cyc < n0 + 2 * 7, 1'b1);
        finish_test();
    end
endmodule // tb
